// ---- src/clock_source_reset_sequencer.sv ----
// Purpose: clock source selection, divisor holding and power-on reset release
// Assumes: all inputs synchronous to clk; power_on_reset_n reaches rst_b too
// Notes: reset output release counted in slow-clock rising edges
`timescale 1ns/10ps
module clock_source_reset_sequencer
    import clk_rst_pkg::*;
#(
    parameter logic [15:0] WAKEUP_RST = WAKEUP_DELAY_RST
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        power_on_reset_n,
    input  wire logic        slow_clock_source_select,
    input  wire logic        slow_osc_input,
    input  wire logic        pin_function_select_b,
    input  wire logic [15:0] wakeup_delay_setup,
    input  wire logic        wakeup_delay_load,
    input  wire div_set_s    div_req,
    input  wire logic        div_load,
    output clk_src_s         clk_src,
    output div_set_s         div_cfg,
    output logic             reset_out_n,
    output logic [15:0]      wakeup_count
);

    // ************************************************************
    // sequencer state
    // ************************************************************
    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_COUNT = 2'b01,
        ST_SLACK = 2'b11,
        ST_RUN   = 2'b10
    } seq_e;

    seq_e        state_r,   state_nxt;
    logic [15:0] setup_r,   setup_nxt;
    logic [15:0] cnt_r,     cnt_nxt;
    logic [15:0] slack_r,   slack_nxt;
    logic        slow_r,    slow_nxt;
    logic        rout_r,    rout_nxt;
    clk_src_s    src_r,     src_nxt;
    div_set_s    div_r,     div_nxt;
    logic        slow_rise;

    // one-step countdown shared by the wakeup and slack counters
    function automatic logic [15:0] dec16(input logic [15:0] v);
        return v - 16'h0001;
    endfunction

    assign slow_rise = slow_osc_input & ~slow_r;

    // next-state computation for every register except the slack helper
    always_comb begin
        state_nxt = state_r;
        setup_nxt = setup_r;
        cnt_nxt   = cnt_r;
        slack_nxt = slack_r;
        slow_nxt  = slow_osc_input;
        rout_nxt  = rout_r;
        src_nxt   = src_r;
        div_nxt   = div_r;
        src_nxt.slow_from_crystal  = slow_clock_source_select;
        src_nxt.base_osc_enable    = pin_function_select_b;
        src_nxt.base_from_external = ~pin_function_select_b;
        if (wakeup_delay_load) begin
            setup_nxt = wakeup_delay_setup;
        end
        if (div_load) begin
            div_nxt.processor   = div_clamp(div_req.processor);
            div_nxt.signal_proc = div_clamp(div_req.signal_proc);
            div_nxt.traffic     = div_clamp(div_req.traffic);
        end
        if (!power_on_reset_n) begin
            state_nxt = ST_HOLD;
            rout_nxt  = 1'b0;
        end else begin
            unique case (state_r)
                ST_HOLD: begin
                    state_nxt = ST_COUNT;
                    cnt_nxt   = setup_r;
                end
                ST_COUNT: begin
                    if (cnt_r == 16'h0000) begin
                        state_nxt = ST_SLACK;
                        slack_nxt = 16'(RELEASE_SLACK_CYC - 1);
                    end else if (slow_rise) begin
                        cnt_nxt = dec16(cnt_r);
                    end
                end
                ST_SLACK: begin
                    if (slack_r == 16'h0000) begin
                        state_nxt = ST_RUN;
                        rout_nxt  = 1'b1;
                    end else begin
                        slack_nxt = dec16(slack_r);
                    end
                end
                ST_RUN: begin
                    rout_nxt = 1'b1;
                end
            endcase
        end
    end

    // registers; reset restores oscillator default and divide by one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_HOLD;
            setup_r <= WAKEUP_RST;
            cnt_r   <= 16'h0000;
            slack_r <= 16'h0000;
            slow_r  <= 1'b0;
            rout_r  <= 1'b0;
            src_r   <= '{slow_from_crystal: 1'b1, base_osc_enable: 1'b1,
                         base_from_external: 1'b0};
            div_r   <= '{processor: DIV_BY_1, signal_proc: DIV_BY_1,
                         traffic: DIV_BY_1};
        end else if (ce) begin
            state_r <= state_nxt;
            setup_r <= setup_nxt;
            cnt_r   <= cnt_nxt;
            slack_r <= slack_nxt;
            slow_r  <= slow_nxt;
            rout_r  <= rout_nxt;
            src_r   <= src_nxt;
            div_r   <= div_nxt;
        end
    end

    assign clk_src      = src_r;
    assign div_cfg      = div_r;
    assign reset_out_n  = rout_r;
    assign wakeup_count = cnt_r;

    // ************************************************************
    // release window helper: cycles spent in the slack stretch
    // ************************************************************
    logic [15:0] since_zero_r, since_zero_nxt;

    // restarts outside slack, saturates rather than wrapping
    always_comb begin
        since_zero_nxt = since_zero_r;
        if (!power_on_reset_n || state_r != ST_SLACK) begin
            since_zero_nxt = 16'h0000;
        end else if (since_zero_r != 16'hFFFF) begin
            since_zero_nxt = since_zero_r + 16'h0001;
        end
    end

    // helper register, frozen with the rest of the block
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            since_zero_r <= 16'h0000;
        end else if (ce) begin
            since_zero_r <= since_zero_nxt;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_out_low_in_reset: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !power_on_reset_n |=> !reset_out_n)
        else $error("reset output high while power-on reset held");
    a_base_default: assert property (@(posedge clk)
        $rose(rst_b) |-> clk_src.base_osc_enable)
        else $error("base oscillator not enabled after reset");
    a_base_ext_sel: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !pin_function_select_b |=> clk_src.base_from_external)
        else $error("external base clock not selected");
    a_slow_sel: assert property (@(posedge clk) disable iff (!rst_b)
        ce |=> clk_src.slow_from_crystal == $past(slow_clock_source_select))
        else $error("slow clock source does not follow pin");
    a_div_load: assert property (@(posedge clk) disable iff (!rst_b)
        ce && div_load |=> div_cfg == $past(div_req))
        else $error("divisor not taken");
    a_release_slack: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state_r == ST_COUNT && cnt_r == 16'h0000 && power_on_reset_n
        ##1 (ce && power_on_reset_n)[*8] |=> !reset_out_n)
        else $error("reset output released before slack");
    a_count_start: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state_r == ST_HOLD && power_on_reset_n |=> cnt_r == $past(setup_r))
        else $error("wakeup count not loaded on release");
    a_rise_only_run: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(reset_out_n) |-> state_r == ST_RUN)
        else $error("reset output rose outside run");
    // released output stands until power-on reset drops again
    a_out_stays_high: assert property (@(posedge clk) disable iff (!rst_b)
        ce && power_on_reset_n && reset_out_n |=> reset_out_n)
        else $error("reset output dropped without power-on reset");
    // one slow rising edge takes exactly one off the count
    a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
        ce && power_on_reset_n && state_r == ST_COUNT && cnt_r != 16'h0000 && slow_rise
        |=> wakeup_count == $past(cnt_r) - 16'h0001)
        else $error("wakeup count did not step on slow edge");
    a_count_hold: assert property (@(posedge clk) disable iff (!rst_b)
        ce && power_on_reset_n && state_r == ST_COUNT && !slow_rise |=> $stable(wakeup_count))
        else $error("wakeup count moved without slow edge");
    // slack stretch never exceeds the ten microsecond allowance
    a_slack_bound: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state_r == ST_SLACK |-> since_zero_r < 16'(RELEASE_SLACK_CYC))
        else $error("slack stretch too long");
    // clock enable low freezes every output
    a_freeze_out: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(reset_out_n) && $stable(clk_src) && $stable(wakeup_count))
        else $error("state moved while clock enable low");
    a_freeze_div: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(div_cfg))
        else $error("divisors moved while clock enable low");
    a_base_exclusive: assert property (@(posedge clk) disable iff (!rst_b)
        clk_src.base_osc_enable != clk_src.base_from_external)
        else $error("base oscillator and external base both selected");
    c_release: cover property (@(posedge clk) disable iff (!rst_b) $rose(reset_out_n));
    c_slack_end: cover property (@(posedge clk) disable iff (!rst_b)
        state_r == ST_SLACK ##1 state_r == ST_RUN);
    c_ext_base: cover property (@(posedge clk) disable iff (!rst_b)
        clk_src.base_from_external);
    c_reassert: cover property (@(posedge clk) disable iff (!rst_b)
        reset_out_n ##1 !power_on_reset_n);
    c_freeze: cover property (@(posedge clk) disable iff (!rst_b) !ce ##1 !ce);

endmodule

// ---- pkg/clk_rst_pkg.sv ----
// Purpose: constants and carrier types for the clock source and reset sequencer
// Assumes: 25 MHz system clock, slow clock arrives as a synchronous input level
// Notes: divisor codes 0..3 stand for divide by 1, 2, 4, 8
package clk_rst_pkg;

    localparam int          CLK_HZ            = 25_000_000;
    localparam int          SLOW_HZ           = 32_768;
    localparam int          RELEASE_SLACK_US  = 10;
    localparam int          RELEASE_SLACK_CYC =
        (RELEASE_SLACK_US * (CLK_HZ / 1_000_000)) > 0 ?
        (RELEASE_SLACK_US * (CLK_HZ / 1_000_000)) : 1;
    localparam logic [15:0] WAKEUP_DELAY_RST  = 16'h03FF;
    localparam int          DIV_W             = 2;
    localparam logic [1:0]  DIV_BY_1          = 2'h0;
    localparam logic [1:0]  DIV_BY_8          = 2'h3;

    // selected clock sources seen by the clock tree
    typedef struct packed {
        logic slow_from_crystal;
        logic base_osc_enable;
        logic base_from_external;
    } clk_src_s;

    // divisor codes for the three derived clocks
    typedef struct packed {
        logic [1:0] processor;
        logic [1:0] signal_proc;
        logic [1:0] traffic;
    } div_set_s;

    // legal code is always one of four; mask keeps the field at 2 bits
    function automatic logic [1:0] div_clamp(input logic [1:0] code);
        return code & DIV_BY_8;
    endfunction

endpackage

// ---- sim/board_reset_model.sv ----
// Purpose: board reset supervisor and external slow clock source
// Assumes: slow clock sped up to 2*HALF system cycles per period
// Notes: reset is released on request only after two slow periods low
`timescale 1ns/10ps
module board_reset_model #(
    parameter int HALF = 8
) (
    input  wire logic clk,
    input  wire logic hold_req,
    output logic      slow_osc_input,
    output logic      power_on_reset_n
);
    int ph = 0;
    int lows = 0;
    initial slow_osc_input = 1'b0;
    initial power_on_reset_n = 1'b0;
    // ****************************************
    // slow clock and reset hold
    // ****************************************
    always @(posedge clk) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1)
            slow_osc_input <= ~slow_osc_input;
        // count slow half periods spent low, four make two periods
        lows <= power_on_reset_n ? 0 : lows + int'(ph == HALF - 1);
        if (hold_req)
            power_on_reset_n <= 1'b0;
        else if (lows >= 4)
            power_on_reset_n <= 1'b1;
    end
endmodule

// ---- sim/test_clock_source_reset_sequencer.sv ----
// Purpose: self-checking bench for clock source and reset sequencer
// Assumes: slow period P of 16 system cycles from the partner model
// Notes: release window checked between (C-1)*P+250 and C*P+256 cycles
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module test_clock_source_reset_sequencer
    import clk_rst_pkg::*;
;
    localparam int HALF = 8;
    localparam int P    = 2 * HALF;
    logic clk = 0, rst_b = 0, ce = 1, hold_req = 1, sel_slow = 1, pfs_b = 1;
    logic slow_in, por_n, setup_ld = 0, div_ld = 0, reset_out_n;
    logic [15:0] setup = 16'h0000, wcount;
    div_set_s    div_req = '0, div_cfg;
    clk_src_s    clk_src;
    int err_total = 0, total_checks = 0, cycles = 0;
    always #20 clk = ~clk;
    board_reset_model #(.HALF(HALF)) board (.clk(clk), .hold_req(hold_req),
        .slow_osc_input(slow_in), .power_on_reset_n(por_n));
    clock_source_reset_sequencer DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
        .power_on_reset_n(por_n), .slow_clock_source_select(sel_slow),
        .slow_osc_input(slow_in), .pin_function_select_b(pfs_b),
        .wakeup_delay_setup(setup), .wakeup_delay_load(setup_ld), .div_req(div_req),
        .div_load(div_ld), .clk_src(clk_src), .div_cfg(div_cfg),
        .reset_out_n(reset_out_n), .wakeup_count(wcount));
    // ****************************************
    // verdict and hang guard
    // ****************************************
    task automatic test_done();
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            test_done();
        end
    end
    // release board reset and time the reset output rise against count c
    task automatic release_check(input int c);
        int n;
        n = 0;
        @(negedge clk);
        `CHK(reset_out_n, 1'b0)
        @(posedge clk) hold_req <= 1'b0;
        while (por_n !== 1'b1) @(negedge clk);
        @(negedge clk);
        `CHK(wcount, 16'(c))
        n = 1;
        while (reset_out_n !== 1'b1 && n < c * P + 300) begin
            @(negedge clk);
            n++;
        end
        `CHK(n >= (c - 1) * P + 250 && n <= c * P + 256, 1'b1)
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        `CHK(clk_src, 3'b110)
        @(posedge clk) rst_b <= 1'b1;
        // every slow and base source selection
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            sel_slow <= i[1];
            pfs_b <= i[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK(clk_src, {i[1], i[0], ~i[0]})
        end
        // every divisor code, held once the load pulse is gone
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            div_req <= {i[1:0], 2'(3 - i), i[1:0]};
            div_ld <= 1'b1;
            @(posedge clk);
            div_ld <= 1'b0;
            div_req <= '1;
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK(div_cfg, {i[1:0], 2'(3 - i), i[1:0]})
        end
        // clock enable low freezes the source selection
        @(posedge clk) ce <= 1'b0;
        pfs_b <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(clk_src, 3'b110)
        @(posedge clk) ce <= 1'b1;
        pfs_b <= 1'b1;
        release_check(int'(WAKEUP_DELAY_RST));
        @(posedge clk);
        hold_req <= 1'b1;
        setup <= 16'h0003;
        setup_ld <= 1'b1;
        @(posedge clk) setup_ld <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK(reset_out_n, 1'b0)
        repeat (5 * HALF) @(posedge clk);
        release_check(3);
        test_done();
    end
endmodule
